/* sks_sequencer.sv */
// Kick and stop sequencer with Wishbone register file
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/100ps
module sks_sequencer
    import sks_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [7:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // Motor side commands, same clock
    input  wire sks_pkg::sks_cmd_t    cmd_i,
    // Power stage drive and interrupt
    output sks_pkg::sks_drive_t       drive_o,
    output logic                      irq_o
);
    import sks_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [9:0]     kick_lvl_reg,  kick_lvl_next;
    logic [6:0]     kick_time_reg, kick_time_next;
    sks_stop_mode_t mode_reg,      mode_next;
    logic           cfs_reg,       cfs_next;
    logic [6:0]     begin_reg,     begin_next;
    logic [6:0]     end_reg,       end_next;
    logic [9:0]     dtime_reg,     dtime_next;
    logic [EV_W-1:0] irq_reg,      irq_next;
    logic [EV_W-1:0] mask_reg,     mask_next;
    logic [31:0]    dat_reg,       dat_next;
    logic           ack_reg,       ack_next;
    logic [EV_W-1:0] ev;
    logic           clamp_ev;

    logic           bus_req;
    logic           wr_en;
    logic [31:0]    rd_val;
    logic [9:0]     lvl_w;
    logic [6:0]     t_w;
    logic [6:0]     b_w;
    logic [6:0]     e_w;
    logic           irq_rd;

    sks_state_t     st_reg, st_next;

    assign bus_req = cyc_i && stb_i && !ack_reg;
    assign wr_en   = bus_req && we_i;
    assign irq_rd  = bus_req && !we_i && (adr_i == ADDR_IRQ);

    always_comb
    begin
        unique case (adr_i)
            ADDR_CTRL:   rd_val = {22'h00_0000, 7'h00, cfs_reg, mode_reg};
            ADDR_KICK:   rd_val = {9'h000, kick_time_reg, 6'h00, kick_lvl_reg};
            ADDR_DECEL:  rd_val = {dtime_reg, 1'b0, end_reg, 7'h00, begin_reg};
            ADDR_STATUS: rd_val = {16'h0000, 6'h00, drive_o.level[9:0]}
                                  | {13'h0000, st_reg, 16'h0000};
            ADDR_IRQ:    rd_val = {28'h000_0000, irq_reg};
            ADDR_MASK:   rd_val = {28'h000_0000, mask_reg};
            default:     rd_val = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        kick_lvl_next  = kick_lvl_reg;
        kick_time_next = kick_time_reg;
        mode_next      = mode_reg;
        cfs_next       = cfs_reg;
        begin_next     = begin_reg;
        end_next       = end_reg;
        dtime_next     = dtime_reg;
        mask_next      = mask_reg;
        clamp_ev       = 1'b0;
        ack_next       = bus_req;
        dat_next       = bus_req && !we_i ? rd_val : 32'h0000_0000;
        lvl_w          = dat_i[9:0];
        t_w            = dat_i[22:16];
        b_w            = dat_i[6:0];
        e_w            = dat_i[22:16];
        if (wr_en)
        begin
            unique case (adr_i)
                ADDR_CTRL:
                begin
                    if (sel_i[0])
                    begin
                        if (dat_i[1:0] != 2'h3)
                            mode_next = sks_stop_mode_t'(dat_i[1:0]);
                        cfs_next = dat_i[2];
                    end
                end
                ADDR_KICK:
                begin
                    if (sel_i[1:0] == 2'h3)
                    begin
                        if (lvl_w == KICK_LVL_OFF)
                            kick_lvl_next = KICK_LVL_OFF;
                        else if (lvl_w < KICK_LVL_MIN)
                            kick_lvl_next = KICK_LVL_MIN;
                        else if (lvl_w > KICK_LVL_MAX)
                            kick_lvl_next = KICK_LVL_MAX;
                        else
                            kick_lvl_next = lvl_w;
                    end
                    if (sel_i[2])
                    begin
                        if (t_w < KICK_TIME_MIN)
                            kick_time_next = KICK_TIME_MIN;
                        else if (t_w > KICK_TIME_MAX)
                            kick_time_next = KICK_TIME_MAX;
                        else
                            kick_time_next = t_w;
                    end
                end
                ADDR_DECEL:
                begin
                    if (sel_i[0])
                    begin
                        if (b_w < BEGIN_MIN)
                            begin_next = BEGIN_MIN;
                        else if (b_w > BEGIN_MAX)
                            begin_next = BEGIN_MAX;
                        else
                            begin_next = b_w;
                    end
                    if (sel_i[2])
                    begin
                        if (e_w < END_MIN)
                            end_next = END_MIN;
                        else if (e_w > END_MAX)
                            end_next = END_MAX;
                        else
                            end_next = e_w;
                    end
                    if (sel_i[3])
                        dtime_next = {dat_i[31:24], dat_i[23:22]};
                end
                ADDR_MASK:
                begin
                    if (sel_i[0])
                        mask_next = dat_i[EV_W-1:0];
                end
                default:
                begin
                end
            endcase
        end
        if (end_next > begin_next)
        begin
            end_next = begin_next;
            clamp_ev = wr_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    logic [23:0] div_reg,   div_next;
    logic [6:0]  kcnt_reg,  kcnt_next;
    logic [9:0]  lvl_reg,   lvl_next;
    logic [9:0]  tgt_reg,   tgt_next;
    logic [9:0]  step_reg,  step_next;
    logic        gate_reg,  gate_next;
    logic        byp_reg,   byp_next;
    logic [6:0]  start_lvl;
    logic        tick;
    logic        decel_tick;
    logic        stop_req;
    logic        ctl_stop;
    logic        do_ramp;
    logic [9:0]  span;

    assign tick       = (div_reg == 24'(KICK_TICK_CYC - 1));
    assign decel_tick = (div_reg % 24'(DECEL_TICK_CYC)) == 24'(DECEL_TICK_CYC - 1);
    assign stop_req   = cmd_i.stop || cmd_i.fault;
    assign ctl_stop   = !cmd_i.fault || (cfs_reg && !cmd_i.fault_coast);
    assign do_ramp    = ctl_stop && (mode_reg != SKS_STOP_COAST);
    // Torque ramp starts from measured load, voltage ramp from begin level
    assign start_lvl  = (mode_reg == SKS_STOP_TRAMP) ? cmd_i.load_pct
                                                     : begin_reg;
    assign span       = {3'h0, start_lvl} > {3'h0, end_reg}
                      ? {3'h0, start_lvl} - {3'h0, end_reg} : 10'h000;

    always_comb
    begin
        st_next   = st_reg;
        div_next  = tick ? 24'h00_0000 : div_reg + 24'h00_0001;
        kcnt_next = kcnt_reg;
        lvl_next  = lvl_reg;
        tgt_next  = tgt_reg;
        step_next = step_reg;
        gate_next = gate_reg;
        byp_next  = byp_reg;
        ev        = '0;
        unique case (st_reg)
            SKS_IDLE:
            begin
                gate_next = 1'b0;
                byp_next  = 1'b0;
                lvl_next  = 10'h000;
                if (cmd_i.start && !cmd_i.fault)
                begin
                    gate_next = 1'b1;
                    div_next  = 24'h00_0000;
                    if (kick_lvl_reg != KICK_LVL_OFF)
                    begin
                        st_next   = SKS_KICK;
                        kcnt_next = kick_time_reg;
                        lvl_next  = kick_lvl_reg;
                    end
                    else
                        st_next = SKS_RAMP;
                end
            end
            SKS_KICK:
            begin
                if (stop_req)
                    st_next = SKS_BYPOFF;
                else if (tick)
                begin
                    kcnt_next = kcnt_reg - 7'h01;
                    if (kcnt_reg == 7'h01)
                    begin
                        st_next  = SKS_RAMP;
                        lvl_next = 10'h000;
                        ev[EV_KICK_DONE] = 1'b1;
                    end
                end
            end
            SKS_RAMP:
            begin
                if (stop_req)
                    st_next = SKS_BYPOFF;
                else if (cmd_i.ramp_done)
                begin
                    st_next  = SKS_RUN;
                    byp_next = 1'b1;
                end
            end
            SKS_RUN:
            begin
                if (stop_req)
                begin
                    if (do_ramp)
                    begin
                        st_next   = SKS_DECEL;
                        lvl_next  = {3'h0, start_lvl};
                        tgt_next  = {3'h0, end_reg};
                        step_next = span / (dtime_reg == 10'h000 ? 10'h001 : dtime_reg);
                        if (step_next == 10'h000)
                            step_next = 10'h001;
                        byp_next  = 1'b0;
                        div_next  = 24'h00_0000;
                    end
                    else
                        st_next = SKS_BYPOFF;
                end
            end
            SKS_DECEL:
            begin
                if (cmd_i.fault && !ctl_stop)
                    st_next = SKS_BYPOFF;
                else if (decel_tick)
                begin
                    if (lvl_reg <= tgt_reg + step_reg)
                    begin
                        lvl_next = tgt_reg;
                        st_next  = SKS_BYPOFF;
                    end
                    else
                        lvl_next = lvl_reg - step_reg;
                end
            end
            SKS_BYPOFF:
            begin
                // Contactor opens one cycle before gating ends
                byp_next = 1'b0;
                if (!byp_reg)
                begin
                    gate_next = 1'b0;
                    lvl_next  = 10'h000;
                    st_next   = SKS_IDLE;
                    ev[EV_STOPPED] = 1'b1;
                end
            end
            default:
                st_next = SKS_IDLE;
        endcase
        ev[EV_FAULT] = cmd_i.fault && (st_reg != SKS_IDLE);
        ev[EV_CLAMP] = clamp_ev;
        irq_next = (irq_rd ? '0 : irq_reg) | ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            kick_lvl_reg  <= KICK_LVL_OFF;
            kick_time_reg <= KICK_TIME_RST;
            mode_reg      <= SKS_STOP_COAST;
            cfs_reg       <= 1'b0;
            begin_reg     <= BEGIN_RST;
            end_reg       <= END_RST;
            dtime_reg     <= DTIME_RST;
            irq_reg       <= '0;
            mask_reg      <= '0;
            dat_reg       <= 32'h0000_0000;
            ack_reg       <= 1'b0;
            st_reg        <= SKS_IDLE;
            div_reg       <= 24'h00_0000;
            kcnt_reg      <= 7'h00;
            lvl_reg       <= 10'h000;
            tgt_reg       <= 10'h000;
            step_reg      <= 10'h000;
            gate_reg      <= 1'b0;
            byp_reg       <= 1'b0;
            drive_o       <= '0;
            irq_o         <= 1'b0;
        end
        else if (ce_i)
        begin
            kick_lvl_reg  <= kick_lvl_next;
            kick_time_reg <= kick_time_next;
            mode_reg      <= mode_next;
            cfs_reg       <= cfs_next;
            begin_reg     <= begin_next;
            end_reg       <= end_next;
            dtime_reg     <= dtime_next;
            irq_reg       <= irq_next;
            mask_reg      <= mask_next;
            dat_reg       <= dat_next;
            ack_reg       <= ack_next;
            st_reg        <= st_next;
            div_reg       <= div_next;
            kcnt_reg      <= kcnt_next;
            lvl_reg       <= lvl_next;
            tgt_reg       <= tgt_next;
            step_reg      <= step_next;
            gate_reg      <= gate_next;
            byp_reg       <= byp_next;
            drive_o.gate_en      <= gate_next;
            drive_o.bypass_on    <= byp_next;
            drive_o.kick_active  <= (st_next == SKS_KICK);
            drive_o.accel_active <= (st_next == SKS_RAMP);
            drive_o.decel_active <= (st_next == SKS_DECEL);
            drive_o.level        <= lvl_next;
            irq_o                <= |(irq_next & mask_next);
        end
    end

    assign dat_o = dat_reg;
    assign ack_o = ack_reg;

endmodule

/* sks_pkg.sv */
// Package with constants, types and register map of the kick and stop sequencer
package sks_pkg;

    localparam int unsigned CLK_HZ          = 125_000_000;
    localparam int unsigned KICK_TICK_MS    = 100;
    localparam int unsigned KICK_TICK_CYC   = CLK_HZ / 1000 * KICK_TICK_MS;
    localparam int unsigned DECEL_TICK_MS   = 10;
    localparam int unsigned DECEL_TICK_CYC  = CLK_HZ / 1000 * DECEL_TICK_MS;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_KICK   = 8'h04;
    localparam logic [7:0] ADDR_DECEL  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ    = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;

    // Field limits and reset values
    localparam logic [9:0] KICK_LVL_OFF  = 10'h000;
    localparam logic [9:0] KICK_LVL_MIN  = 10'h064;
    localparam logic [9:0] KICK_LVL_MAX  = 10'h320;
    localparam logic [6:0] KICK_TIME_MIN = 7'h01;
    localparam logic [6:0] KICK_TIME_MAX = 7'h64;
    localparam logic [6:0] KICK_TIME_RST = 7'h0A;
    localparam logic [6:0] BEGIN_MIN     = 7'h01;
    localparam logic [6:0] BEGIN_MAX     = 7'h64;
    localparam logic [6:0] BEGIN_RST     = 7'h28;
    localparam logic [6:0] END_MIN       = 7'h01;
    localparam logic [6:0] END_MAX       = 7'h63;
    localparam logic [6:0] END_RST       = 7'h14;
    localparam logic [9:0] DTIME_RST     = 10'h00A;

    // Interrupt event bit positions
    localparam int unsigned EV_KICK_DONE = 0;
    localparam int unsigned EV_STOPPED   = 1;
    localparam int unsigned EV_FAULT     = 2;
    localparam int unsigned EV_CLAMP     = 3;
    localparam int unsigned EV_W         = 4;

    typedef enum logic [1:0] {
        SKS_STOP_COAST  = 2'h0,
        SKS_STOP_VRAMP  = 2'h1,
        SKS_STOP_TRAMP  = 2'h2
    } sks_stop_mode_t;

    typedef enum logic [2:0] {
        SKS_IDLE   = 3'b000,
        SKS_KICK   = 3'b001,
        SKS_RAMP   = 3'b011,
        SKS_RUN    = 3'b010,
        SKS_DECEL  = 3'b110,
        SKS_BYPOFF = 3'b111
    } sks_state_t;

    typedef struct packed {
        logic        start;
        logic        stop;
        logic        fault;
        logic        fault_coast;
        logic [6:0]  load_pct;
        logic        ramp_done;
    } sks_cmd_t;

    typedef struct packed {
        logic        gate_en;
        logic        bypass_on;
        logic        kick_active;
        logic        accel_active;
        logic        decel_active;
        logic [9:0]  level;
    } sks_drive_t;

endpackage

/* sks_properties.sv */
// Checker of the kick and stop sequencer port behaviour
`timescale 1ns/100ps
module sks_properties
    import sks_pkg::*;
(
    // Clock, reset, enable
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    // Wishbone slave
    input wire logic                cyc_i,
    input wire logic                stb_i,
    input wire logic                we_i,
    input wire logic [7:0]          adr_i,
    input wire logic [3:0]          sel_i,
    input wire logic [31:0]         dat_i,
    input wire logic [31:0]         dat_o,
    input wire logic                ack_o,
    // Motor side
    input wire sks_pkg::sks_cmd_t   cmd_i,
    input wire sks_pkg::sks_drive_t drive_o,
    input wire logic                irq_o
);
    logic [1:0]  mode;
    logic [31:0] klen;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Shadow of the stop mode and length of the current kick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode <= 2'h0;
        else if (cyc_i && stb_i && we_i && ack_o && adr_i == ADDR_CTRL && sel_i[0]
                 && dat_i[1:0] != 2'h3)
            mode <= dat_i[1:0];
        if (rst_i || !drive_o.kick_active)
            klen <= 32'h0000_0000;
        else
            klen <= klen + 32'h0000_0001;
    end

    sequence s_gate_off;
        drive_o.gate_en ##1 !drive_o.gate_en;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence
    sequence s_coast_off;
        !drive_o.decel_active ##1 !drive_o.bypass_on ##1 !drive_o.gate_en;
    endsequence

    property p_ack;
        ce_i && cyc_i && stb_i && !ack_o |=> s_ack_pulse;
    endproperty
    property p_rdata;
        !ack_o |-> dat_o == 32'h0000_0000;
    endproperty
    property p_kick_excl;
        drive_o.kick_active |-> drive_o.gate_en && !drive_o.accel_active && !drive_o.bypass_on;
    endproperty
    property p_kick_hold;
        $fell(drive_o.kick_active) && !$past(cmd_i.stop || cmd_i.fault)
            |-> klen >= KICK_TICK_CYC - 1 && drive_o.accel_active;
    endproperty
    property p_coast;
        $fell(drive_o.bypass_on) && !drive_o.decel_active |-> s_gate_off;
    endproperty
    property p_decel_entry;
        $rose(drive_o.decel_active) |-> drive_o.gate_en && !drive_o.bypass_on;
    endproperty
    property p_decel_fall;
        drive_o.decel_active && $past(drive_o.decel_active)
            |-> drive_o.level <= $past(drive_o.level);
    endproperty
    property p_torque;
        $rose(drive_o.decel_active) && mode == 2'h2
            |-> drive_o.level == {3'h0, $past(cmd_i.load_pct)};
    endproperty
    property p_fault;
        drive_o.gate_en && !drive_o.decel_active && cmd_i.fault
            |=> !drive_o.kick_active && !drive_o.accel_active ##1 !drive_o.bypass_on;
    endproperty
    property p_fault_coast;
        drive_o.bypass_on && cmd_i.fault && cmd_i.fault_coast
            |=> s_coast_off;
    endproperty
    property p_coast_mode;
        drive_o.bypass_on && cmd_i.stop && mode == 2'h0
            |=> s_coast_off;
    endproperty

    a_ack: assert property (p_ack) else $error("ack not one pulse after request");
    a_rdata: assert property (p_rdata) else $error("read data not zero outside ack");
    a_kick_excl: assert property (p_kick_excl) else $error("kick overlaps ramp");
    a_kick_hold: assert property (p_kick_hold) else $error("kick too short");
    a_coast: assert property (p_coast) else $error("gating not after bypass open");
    a_decel_entry: assert property (p_decel_entry) else $error("bad decel entry");
    a_decel_fall: assert property (p_decel_fall) else $error("decel level rose");
    a_torque: assert property (p_torque) else $error("torque start not load");
    a_fault: assert property (p_fault) else $error("fault did not stop motor");
    a_fault_coast: assert property (p_fault_coast) else $error("forced coast missed");
    a_coast_mode: assert property (p_coast_mode) else $error("coast mode decelerated");
endmodule

bind sks_sequencer sks_properties u_sks_properties (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cmd_i(cmd_i), .drive_o(drive_o), .irq_o(irq_o)
);

/* sks_motor_model.sv */
// Behavioural power stage and motor facing the sequencer
`timescale 1ns/100ps
module sks_motor_model
    import sks_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Drive from the sequencer, run-up length in cycles
    input  wire sks_pkg::sks_drive_t drive_i,
    input  wire logic [7:0]          ramp_cyc_i,
    // Motor feedback
    output logic                     ramp_done_o,
    output logic [6:0]               load_pct_o
);
    int unsigned cnt;

    // Speed reached after ramp_cyc_i + 1 cycles of acceleration; new load while stopped
    always @(posedge clk_i)
    begin
        if (rst_i || !drive_i.accel_active)
        begin
            cnt <= 0;
            ramp_done_o <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 1;
            ramp_done_o <= (cnt >= ramp_cyc_i);
        end
        if (rst_i)
            load_pct_o <= 7'h32;
        else if (!drive_i.gate_en)
            load_pct_o <= 7'($urandom_range(100, 30));
    end
endmodule

/* tb_sks_sequencer.sv */
// Self-checking bench of the kick and stop sequencer
`timescale 1ns/100ps
module tb_sks_sequencer;
    import sks_pkg::*;
    logic        clk_i, rst_i, cyc, stb, we, ack, irq, start, stop, fault, fco, rdone, dex;
    logic [7:0]  adr, rc;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rbus;
    logic [6:0]  load;
    logic [9:0]  lv;
    logic [5:0]  cs;
    sks_cmd_t    cmd;
    sks_drive_t  drv;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          n, kv, tv, b;
    int          kl_tab[5] = '{0, 50, 100, 800, 900};
    int          kt_tab[5] = '{0, 1, 100, 127, 7};
    // Stop cases: mode, controlled fault stop, stop, fault, fault coast
    logic [5:0]  cases[6] = '{6'h04, 6'h14, 6'h24, 6'h12, 6'h1A, 6'h2B};

    assign cmd = '{start, stop, fault, fco, load, rdone};

    sks_sequencer u_sks_sequencer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rbus),
        .ack_o(ack), .cmd_i(cmd), .drive_o(drv), .irq_o(irq));
    sks_motor_model u_sks_motor_model (.clk_i(clk_i), .rst_i(rst_i), .drive_i(drv),
        .ramp_cyc_i(rc), .ramp_done_o(rdone), .load_pct_o(load));

    function automatic int klim(int v);
        return v == 0 ? 0 : (v < 100 ? 100 : (v > 800 ? 800 : v));
    endfunction
    function automatic int tlim(int v);
        return v < 1 ? 1 : (v > 100 ? 100 : v);
    endfunction

    task automatic stop_test;
        $display("Counts: %0d compared, %0d mismatched", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        q = rbus;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, s, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 4'hF, 32'h0000_0000, q);
    endtask

    task automatic pulse_start;
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
    endtask

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        {rst_i, cyc, stb, we, start, stop, fault, fco} = 8'h80;
        {adr, sel, wdat, rc} = '0;
        void'($urandom(64));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADDR_KICK, rdat);
        chk(rdat, {9'h0, KICK_TIME_RST, 6'h0, KICK_LVL_OFF});
        rd(ADDR_CTRL, rdat);
        chk(32'(rdat[1:0]), 32'h0);
        rd(ADDR_DECEL, rdat);
        chk(32'({rdat[20:14], rdat[6:0]}), 32'({7'd20, 7'd40}));
        wr(ADDR_STATUS, 4'hF, 32'hFFFF_FFFF);
        rd(ADDR_STATUS, rdat);
        chk(rdat, 32'h0);
        wr(8'h20, 4'hF, $urandom);
        rd(8'h20, rdat);
        chk(rdat, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            kv = i < 5 ? kl_tab[i] : $urandom_range(1023, 0);
            tv = i < 5 ? kt_tab[i] : $urandom_range(127, 0);
            wr(ADDR_KICK, 4'h7, {9'h0, 7'(tv), 6'h0, 10'(kv)});
            rd(ADDR_KICK, rdat);
            chk(rdat, {9'h0, 7'(tlim(tv)), 6'h0, 10'(klim(kv))});
        end
        // End above begin is clamped and raises a maskable event
        for (int m = 0; m < 2; m++)
        begin
            wr(ADDR_MASK, 4'hF, m == 0 ? 32'h0 : 32'h8);
            wr(ADDR_DECEL, 4'h7, {9'h0, 7'd50, 9'h0, 7'd30});
            rd(ADDR_DECEL, rdat);
            chk(32'({rdat[20:14], rdat[6:0]}), 32'({7'd30, 7'd30}));
            chk(32'(irq), 32'(m));
            rd(ADDR_IRQ, rdat);
            chk(32'(rdat[3]), 32'h1);
            repeat (2) @(posedge clk_i);
            chk(32'(irq), 32'h0);
        end
        // Kick entered first, stop during kick opens gating
        wr(ADDR_KICK, 4'h7, {9'h0, 7'd1, 6'h0, 10'd200});
        pulse_start();
        repeat (2) @(posedge clk_i);
        chk(32'({drv.kick_active, drv.accel_active, drv.gate_en}), 32'h5);
        rd(ADDR_STATUS, rdat);
        chk(32'(rdat[18:16]), 32'(SKS_KICK));
        stop <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(32'({drv.kick_active, drv.gate_en}), 32'h0);
        stop <= 1'b0;
        foreach (cases[i])
        begin
            cs = cases[i];
            b = $urandom_range(100, 30);
            rc <= 8'($urandom_range(50, 1));
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            wr(ADDR_MASK, 4'hF, 32'h0000_0004);
            wr(ADDR_DECEL, 4'h7, {9'h0, 7'd20, 9'h0, 7'(b)});
            wr(ADDR_CTRL, 4'h1, 32'({cs[3], cs[5:4]}));
            pulse_start();
            n = 0;
            while (drv.bypass_on !== 1'b1 && n < 500)
            begin
                @(posedge clk_i);
                n++;
            end
            rd(ADDR_STATUS, rdat);
            chk(32'(rdat[18:16]), 32'(SKS_RUN));
            dex = cs[5:4] != 2'h0 && (cs[2] || (cs[1] && cs[3] && !cs[0]));
            lv = cs[5:4] == 2'h1 ? 10'(b) : {3'h0, load};
            @(posedge clk_i);
            stop <= cs[2];
            fault <= cs[1];
            fco <= cs[0];
            repeat (2) @(posedge clk_i);
            chk(32'(drv.decel_active), 32'(dex));
            chk(32'({drv.bypass_on, drv.gate_en}), 32'({!dex, 1'b1}));
            if (dex)
                chk(32'(drv.level), 32'(lv));
            @(posedge clk_i);
            chk(32'({drv.bypass_on, drv.gate_en}), 32'h1);
            @(posedge clk_i);
            chk(32'(drv.gate_en), 32'(dex));
            chk(32'(irq), 32'(cs[1]));
            stop <= 1'b0;
            fault <= 1'b0;
            fco <= 1'b0;
        end
        stop_test();
    end
endmodule
